// ---- logic/irm_pkg.sv ----
package irm_pkg;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam int NLINES = 6;
    localparam logic [IDX_W-1:0] IDX_REQ = 10'h0fa;
    localparam logic [IDX_W-1:0] IDX_MASK = 10'h0fb;
    localparam logic [IDX_W-1:0] IDX_STAT = 10'h0fc;
    localparam logic [IDX_W-1:0] IDX_IMSK = 10'h0fd;
    localparam logic [7:0] REQ_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam int MASTER_BIT = 7;
    localparam int RSVD_BIT = 6;
    localparam int EDGE_HI = 7;
    localparam int EDGE_LO = 6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic irm_hit(input logic [IDX_W-1:0] idx);
        irm_hit = (idx == IDX_REQ) || (idx == IDX_MASK) || (idx == IDX_STAT) || (idx == IDX_IMSK);
    endfunction

    // returns {rise_en, fall_en}; line 0 is port3_line1, line 1 is port3_line2
    function automatic logic [1:0] irm_edge_en(input logic [1:0] sel, input logic line);
        logic r;
        logic f;
        r = line ? sel[0] : sel[1];
        f = line ? (sel != 2'h1) : (sel != 2'h2);
        irm_edge_en = {r, f};
    endfunction
endpackage

// ---- logic/irm_pin_edge.sv ----
module irm_pin_edge import irm_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin,
    input wire logic rise_en,
    input wire logic fall_en,
    output logic edge_q
);
    logic s1_q, s1_d, s2_q, s2_d, prev_q, prev_d, edge_d;

    always_comb begin
        s1_d = pin;
        s2_d = s1_q;
        prev_d = s2_q;
        edge_d = (rise_en && s2_q && !prev_q) || (fall_en && !s2_q && prev_q);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            prev_q <= 1'b0;
            edge_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            prev_q <= prev_d;
            edge_q <= edge_d;
        end
    end
endmodule

// ---- logic/irm_axil.sv ----
module irm_axil import irm_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_en,
    output logic [IDX_W-1:0] wr_idx,
    output logic [7:0] wr_data,
    output logic rd_en,
    output logic [IDX_W-1:0] rd_idx,
    input wire logic [7:0] rd_data
);
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [7:0] wdata_q, wdata_d;
    logic wlane_q, wlane_d;
    logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic [1:0] bresp_d, rresp_d;
    logic [31:0] rdata_d;
    logic aw_now, w_now, fire, lane;
    logic [ADDR_W-1:0] a;

    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wlane_d = wlane_q;
        bvalid_d = bvalid && !bready;
        bresp_d = bresp;
        if (awvalid && awready) begin
            aw_have_d = 1'b1;
            awaddr_d = awaddr;
        end
        if (wvalid && wready) begin
            w_have_d = 1'b1;
            wdata_d = wdata[7:0];
            wlane_d = wstrb[0];
        end
        aw_now = aw_have_d;
        w_now = w_have_d;
        a = awaddr_d;
        lane = wlane_d;
        fire = aw_now && w_now && !bvalid;
        wr_en = fire && irm_hit(a[ADDR_W-1:2]) && lane;
        wr_idx = a[ADDR_W-1:2];
        wr_data = wdata_d;
        if (fire) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = irm_hit(a[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
        rd_en = arvalid && arready && irm_hit(araddr[ADDR_W-1:2]);
        rd_idx = araddr[ADDR_W-1:2];
        rvalid_d = rvalid && !rready;
        rdata_d = rdata;
        rresp_d = rresp;
        if (arvalid && arready) begin
            rvalid_d = 1'b1;
            rdata_d = irm_hit(araddr[ADDR_W-1:2]) ? {24'h000000, rd_data} : 32'h00000000;
            rresp_d = irm_hit(araddr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
        end
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 8'h00;
            wlane_q <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wlane_q <= wlane_d;
            awready <= awready_d;
            wready <= wready_d;
            bvalid <= bvalid_d;
            bresp <= bresp_d;
            arready <= arready_d;
            rvalid <= rvalid_d;
            rdata <= rdata_d;
            rresp <= rresp_d;
        end
    end
endmodule

// ---- logic/irm_top.sv ----
module irm_top import irm_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic port3_line1,
    input wire logic port3_line2,
    input wire logic port3_line3,
    input wire logic low_voltage_evt,
    input wire logic eight_bit_timer_evt,
    input wire logic sixteen_bit_timer_evt,
    input wire logic stop_recovery_evt,
    input wire logic serial_tx_evt,
    input wire logic baud_generator_evt,
    input wire logic serial_rx_evt,
    input wire logic enable_interrupts_instr,
    input wire logic global_mask_instr,
    input wire logic service_ack,
    input wire logic [2:0] service_line,
    output logic [NLINES-1:0] int_pending,
    output logic int_take,
    output logic [15:0] vector_addr,
    output logic irq
);
    logic [7:0] req_q, req_d, msk_q, msk_d, rd_data;
    logic [NLINES-1:0] st_q, st_d, imsk_q, imsk_d, hw_set, pend_d;
    logic en_seen_q, en_seen_d, take_d, irq_d;
    logic [15:0] vec_d;
    logic wr_en, rd_en;
    logic [IDX_W-1:0] wr_idx, rd_idx;
    logic [7:0] wr_data;
    logic [2:0] pin_v, rise_v, fall_v, edge_v;

    irm_axil u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .rd_en(rd_en),
        .rd_idx(rd_idx),
        .rd_data(rd_data)
    );

    // edge enables per pin: 0 port3_line1, 1 port3_line2, 2 port3_line3 (falling only)
    always_comb begin
        pin_v = {port3_line3, port3_line2, port3_line1};
        {rise_v[0], fall_v[0]} = irm_edge_en(req_q[EDGE_HI:EDGE_LO], 1'b0);
        {rise_v[1], fall_v[1]} = irm_edge_en(req_q[EDGE_HI:EDGE_LO], 1'b1);
        rise_v[2] = 1'b0;
        fall_v[2] = 1'b1;
    end

    for (genvar g = 0; g < 3; g++) begin : g_pin
        irm_pin_edge u_edge (
            .aclk(aclk),
            .aresetn(aresetn),
            .pin(pin_v[g]),
            .rise_en(rise_v[g]),
            .fall_en(fall_v[g]),
            .edge_q(edge_v[g])
        );
    end

    // request register, mask register and grant
    always_comb begin
        hw_set[5] = low_voltage_evt;
        hw_set[4] = eight_bit_timer_evt;
        hw_set[3] = sixteen_bit_timer_evt;
        hw_set[2] = edge_v[0];
        hw_set[1] = edge_v[2] || stop_recovery_evt || serial_tx_evt || baud_generator_evt;
        hw_set[0] = edge_v[1] || serial_rx_evt;
        en_seen_d = en_seen_q || enable_interrupts_instr;
        req_d = req_q;
        if (wr_en && wr_idx == IDX_REQ && en_seen_q) begin
            req_d = wr_data;
        end
        if (service_ack && service_line < 3'(NLINES)) begin
            req_d[service_line] = 1'b0;
        end
        req_d[NLINES-1:0] = req_d[NLINES-1:0] | hw_set;
        msk_d = msk_q;
        if (wr_en && wr_idx == IDX_MASK) begin
            msk_d = wr_data;
            msk_d[RSVD_BIT] = 1'b0;
        end
        if (global_mask_instr || service_ack) begin
            msk_d[MASTER_BIT] = 1'b0;
        end
        if (enable_interrupts_instr) begin
            msk_d[MASTER_BIT] = 1'b1;
        end
        pend_d = req_q[NLINES-1:0] & msk_q[NLINES-1:0] & {NLINES{msk_q[MASTER_BIT]}};
        take_d = |pend_d;
        vec_d = vector_addr;
        if (service_ack) begin
            vec_d = {12'h000, service_line, 1'b0};
        end
    end

    // sticky event status, read clears, set wins
    always_comb begin
        st_d = st_q;
        if (rd_en && rd_idx == IDX_STAT) begin
            st_d = '0;
        end
        st_d = st_d | hw_set;
        imsk_d = imsk_q;
        if (wr_en && wr_idx == IDX_IMSK) begin
            imsk_d = wr_data[NLINES-1:0];
        end
        irq_d = |(st_q & imsk_q);
    end

    always_comb begin
        unique case (rd_idx)
            IDX_REQ: rd_data = req_q;
            IDX_MASK: rd_data = {msk_q[MASTER_BIT], 1'b0, msk_q[NLINES-1:0]};
            IDX_STAT: rd_data = {2'h0, st_q};
            IDX_IMSK: rd_data = {2'h0, imsk_q};
            default: rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_q <= REQ_RST;
            msk_q <= MASK_RST;
            en_seen_q <= 1'b0;
            st_q <= '0;
            imsk_q <= '0;
            int_pending <= '0;
            int_take <= 1'b0;
            vector_addr <= 16'h0000;
            irq <= 1'b0;
        end else begin
            req_q <= req_d;
            msk_q <= msk_d;
            en_seen_q <= en_seen_d;
            st_q <= st_d;
            imsk_q <= imsk_d;
            int_pending <= pend_d;
            int_take <= take_d;
            vector_addr <= vec_d;
            irq <= irq_d;
        end
    end
endmodule

// ---- sim/irm_checker.sv ----
module irm_checker import irm_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic enable_interrupts_instr,
    input wire logic global_mask_instr,
    input wire logic service_ack,
    input wire logic [2:0] service_line,
    input wire logic [NLINES-1:0] int_pending,
    input wire logic int_take,
    input wire logic [15:0] vector_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_svc;
        service_ack && !enable_interrupts_instr ##1 !enable_interrupts_instr;
    endsequence
    sequence s_gmask;
        global_mask_instr && !enable_interrupts_instr ##1 !enable_interrupts_instr;
    endsequence
    a_take_or: assert property (int_take == (|int_pending))
        else $error("take is not the or of pending");
    a_vec_load: assert property (service_ack && service_line < 3'h6 |=>
        vector_addr == {12'h000, $past(service_line), 1'b0}) else $error("vector address wrong");
    a_vec_stable: assert property ($past(aresetn) && !$past(service_ack) |-> $stable(vector_addr))
        else $error("vector moved without service");
    a_svc_quiet: assert property (s_svc |=> int_pending == 6'h00)
        else $error("pending after service");
    a_gmask_quiet: assert property (s_gmask |=> int_pending == 6'h00)
        else $error("pending with master off");
    a_rst_quiet: assert property ($rose(aresetn) |-> int_pending == 6'h00 ##1 int_pending == 6'h00)
        else $error("pending after reset");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read upper bits set");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
endmodule
bind irm_top irm_checker chk (.*);

// ---- sim/irm_core_model.sv ----
module irm_core_model (
    input wire logic aclk,
    input wire logic auto_en,
    input wire logic [5:0] int_pending,
    output logic enable_interrupts_instr,
    output logic global_mask_instr,
    output logic service_ack,
    output logic [2:0] service_line
);
    timeunit 1ns;
    timeprecision 1ns;
    logic done = 1'b0;
    initial begin
        enable_interrupts_instr = 1'b0;
        global_mask_instr = 1'b0;
        service_ack = 1'b0;
        service_line = 3'h0;
    end
    task automatic enable_pulse();
        @(posedge aclk) enable_interrupts_instr <= 1'b1;
        @(posedge aclk) enable_interrupts_instr <= 1'b0;
    endtask
    task automatic mask_pulse();
        @(posedge aclk) global_mask_instr <= 1'b1;
        @(posedge aclk) global_mask_instr <= 1'b0;
    endtask
    // one service of the lowest pending line per enable
    always @(posedge aclk) begin
        service_ack <= 1'b0;
        if (!auto_en) begin
            done <= 1'b0;
        end else if (!done && int_pending != 6'h00) begin
            done <= 1'b1;
            service_ack <= 1'b1;
            for (int i = 5; i >= 0; i--) if (int_pending[i]) service_line <= 3'(i);
        end
    end
endmodule

// ---- sim/irm_tb_top.sv ----
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; $display("BAD %0t %h %h", $time, a, e); end end
module irm_tb_top import irm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [5:0] EXB [7] = '{6'h01, 6'h02, 6'h02, 6'h02, 6'h08, 6'h10, 6'h20};
    logic aclk = 0, aresetn = 0, auto_en = 0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic port3_line1 = 0, port3_line2 = 0, port3_line3 = 0;
    logic [6:0] ev = '0;
    wire logic low_voltage_evt, eight_bit_timer_evt, sixteen_bit_timer_evt, stop_recovery_evt;
    wire logic serial_tx_evt, baud_generator_evt, serial_rx_evt;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, int_take, irq;
    logic enable_interrupts_instr, global_mask_instr, service_ack;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] service_line;
    logic [5:0] int_pending;
    logic [15:0] vector_addr;
    logic [7:0] rd;
    int error_cnt = 0, n_tests = 0;
    assign {low_voltage_evt, eight_bit_timer_evt, sixteen_bit_timer_evt, stop_recovery_evt,
        serial_tx_evt, baud_generator_evt, serial_rx_evt} = ev;
    always #25 aclk = ~aclk;
    irm_top dut (.*);
    irm_core_model core (.*);
    task automatic close_out();
        if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] d, input logic [1:0] er);
        bit a;
        bit w;
        @(posedge aclk);
        a = 0;
        w = 0;
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(a && w)) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1 && s_axi_awvalid) a = 1;
            if (s_axi_wready === 1'b1 && s_axi_wvalid) w = 1;
            if (a) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
    endtask
    task automatic rdr(input logic [IDX_W-1:0] i, output logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!(s_axi_arready === 1'b1 && s_axi_arvalid));
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata[7:0];
        `CHK(s_axi_rresp, er)
    endtask
    task automatic rc(input logic [IDX_W-1:0] i, input logic [7:0] e);
        rdr(i, rd, RESP_OKAY);
        `CHK(rd, e)
    endtask
    task automatic evp(input logic [6:0] v);
        @(posedge aclk) ev <= v;
        @(posedge aclk) ev <= 7'h00;
    endtask
    // ln 0 line1 to bit2, 1 line2 to bit0, 2 line3 to bit1
    task automatic pin(input int s, input int ln, input logic v, input logic e);
        logic [1:0] sel;
        sel = s[1:0];
        wr(IDX_REQ, {sel, 6'h00}, RESP_OKAY);
        @(posedge aclk);
        if (ln == 0) port3_line1 <= v;
        else if (ln == 1) port3_line2 <= v;
        else port3_line3 <= v;
        tk(6);
        rc(IDX_REQ, {sel, 3'b000, ln == 0 && e, ln == 2 && e, ln == 1 && e});
    endtask
    initial begin
        #2000000;
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rc(IDX_REQ, REQ_RST);
        rdr(IDX_MASK, rd, RESP_OKAY);
        `CHK(rd[MASTER_BIT], 1'b0)
        wr(IDX_REQ, 8'h3f, RESP_OKAY);
        rc(IDX_REQ, 8'h00);
        wr(10'h0f0, 8'h01, RESP_SLVERR);
        rdr(10'h0f0, rd, RESP_SLVERR);
        core.enable_pulse();
        core.mask_pulse();
        wr(IDX_MASK, 8'h3f, RESP_OKAY);
        core.enable_pulse();
        rc(IDX_MASK, 8'hbf);
        for (int b = 0; b < 6; b++) begin
            wr(IDX_REQ, 8'h01 << b, RESP_OKAY);
            tk(2);
            `CHK(int_pending, 6'h01 << b)
            rc(IDX_REQ, 8'h01 << b);
            wr(IDX_REQ, 8'h00, RESP_OKAY);
            tk(2);
            `CHK(int_pending, 6'h00)
        end
        wr(IDX_REQ, 8'h3e, RESP_OKAY);
        tk(2);
        `CHK(int_pending, 6'h3e)
        core.mask_pulse();
        tk(2);
        `CHK(int_pending, 6'h00)
        wr(IDX_MASK, 8'h21, RESP_OKAY);
        tk(2);
        `CHK(int_pending, 6'h00)
        core.enable_pulse();
        tk(2);
        `CHK(int_pending, 6'h20)
        `CHK(int_take, 1'b1)
        @(posedge aclk) auto_en <= 1'b1;
        tk(4);
        `CHK(vector_addr, 16'h000a)
        `CHK(int_pending, 6'h00)
        rc(IDX_REQ, 8'h1e);
        @(posedge aclk) auto_en <= 1'b0;
        wr(IDX_REQ, 8'h00, RESP_OKAY);
        for (int k = 0; k < 7; k++) begin
            evp(7'h01 << k);
            rc(IDX_REQ, {2'b00, EXB[k]});
            wr(IDX_REQ, 8'h00, RESP_OKAY);
        end
        rc(IDX_STAT, 8'h3b);
        rc(IDX_STAT, 8'h00);
        wr(IDX_IMSK, 8'h10, RESP_OKAY);
        evp(7'h20);
        tk(2);
        `CHK(irq, 1'b1)
        rc(IDX_STAT, 8'h10);
        tk(2);
        `CHK(irq, 1'b0)
        evp(7'h10);
        tk(2);
        `CHK(irq, 1'b0)
        for (int s = 0; s < 4; s++) begin
            pin(s, 0, 1'b1, s[1]);
            pin(s, 0, 1'b0, s != 2);
            pin(s, 1, 1'b1, s[0]);
            pin(s, 1, 1'b0, s != 1);
        end
        pin(0, 2, 1'b1, 1'b0);
        pin(0, 2, 1'b0, 1'b1);
        close_out();
    end
endmodule
